// *** verilog/vectored_irq_unit.sv ***
//------------------------------------------------------------------------------
// Purpose : Vectored interrupt controller, 19 channels, 16 vectored slots
// Assumes : Request inputs are level, active high, on the clk domain
// Notes   : Register port is plain strobes with read data one cycle later
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`timescale 1ns/100ps

module vectored_irq_unit
   import irq_ctrl_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                reset_n,
   // Register port
   input  wire logic [ADDR_W-1:0]   reg_addr,
   input  wire logic [DATA_W-1:0]   reg_wdata,
   input  wire logic                reg_write,
   input  wire logic                reg_read,
   output logic [DATA_W-1:0]        reg_rdata,
   // Peripheral flags
   input  wire logic                watchdog_request,
   input  wire logic                debug_comm_receive,
   input  wire logic                debug_comm_transmit,
   input  wire logic [3:0]          timer0_match,
   input  wire logic [3:0]          timer1_match,
   input  wire logic [3:0]          uart0_causes,
   input  wire logic [3:0]          uart1_causes,
   input  wire logic                modem_status_change,
   input  wire logic [6:0]          pwm_match,
   input  wire logic                twi_state_change,
   input  wire logic [1:0]          spi0_causes,
   input  wire logic [1:0]          spi1_causes,
   input  wire logic                pll_locked,
   input  wire logic                rtc_increment_flag,
   input  wire logic                rtc_alarm_flag,
   input  wire logic [3:0]          external_irq,
   input  wire logic                adc_done,
   // Processor side
   output logic                     fast_irq_output,
   output logic                     normal_irq_output
);

   // -------------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------------
   logic [NUM_CHAN-1:0]  fast_sel_ff;
   logic [NUM_CHAN-1:0]  enable_ff;
   logic [NUM_CHAN-1:0]  soft_ff;
   logic [DATA_W-1:0]    def_addr_ff;
   logic [DATA_W-1:0]    slot_addr_ff [NUM_SLOTS];
   logic [CHAN_W-1:0]    slot_chan_ff [NUM_SLOTS];
   logic [NUM_SLOTS-1:0] slot_en_ff;
   logic [NUM_CHAN-1:0]  raw;
   logic [NUM_CHAN-1:0]  active;
   logic [NUM_CHAN-1:0]  fast_act;
   logic [NUM_CHAN-1:0]  norm_act;
   logic [NUM_SLOTS-1:0] slot_hit;
   logic [DATA_W-1:0]    nxt_vect;
   logic [DATA_W-1:0]    nxt_rdata;

   // -------------------------------------------------------------------------
   // Source merging
   // -------------------------------------------------------------------------
   // Each peripheral's flags are ORed into one line per channel, except the four external inputs, which take channels 14 to 17 one each
   always_comb
   begin
      raw                = '0;
      raw[CH_WATCHDOG]   = watchdog_request;
      raw[CH_SOFT]       = 1'b0;
      raw[CH_DBG_RX]     = debug_comm_receive;
      raw[CH_DBG_TX]     = debug_comm_transmit;
      raw[CH_TIMER0]     = |timer0_match;
      raw[CH_TIMER1]     = |timer1_match;
      raw[CH_UART0]      = |uart0_causes;
      raw[CH_UART1]      = (|uart1_causes) | modem_status_change;
      raw[CH_PWM]        = |pwm_match;
      raw[CH_TWI]        = twi_state_change;
      raw[CH_SPI0]       = |spi0_causes;
      raw[CH_SPI1]       = |spi1_causes;
      raw[CH_PLL]        = pll_locked;
      raw[CH_RTC]        = rtc_increment_flag | rtc_alarm_flag;
      raw[CH_EXT0 +: 4]  = external_irq;
      raw[CH_ADC]        = adc_done;
   end

   // Software raised requests join the level inputs, then enable gates them
   assign active   = (raw | soft_ff) & enable_ff;
   assign fast_act = active & fast_sel_ff;
   assign norm_act = active & ~fast_sel_ff;

   // -------------------------------------------------------------------------
   // Slot matching
   // -------------------------------------------------------------------------
   // Each enabled slot watches its chosen channel among normal requests
   generate
      for (genvar s = 0; s < NUM_SLOTS; s++)
      begin : g_slot
         assign slot_hit[s] = slot_en_ff[s] && (slot_chan_ff[s] < CHAN_W'(NUM_CHAN))
                              && norm_act[slot_chan_ff[s]];
      end
   endgenerate

   // Lowest numbered hit wins; otherwise the shared default address
   always_comb
   begin
      nxt_vect = def_addr_ff;
      for (int s = NUM_SLOTS - 1; s >= 0; s--)
      begin
         if (slot_hit[s])
         begin
            nxt_vect = slot_addr_ff[s];
         end
      end
   end

   // -------------------------------------------------------------------------
   // Processor outputs
   // -------------------------------------------------------------------------
   // Registered so outputs follow the inputs one clock later
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fast_irq_output   <= 1'b0;
         normal_irq_output <= 1'b0;
      end
      else
      begin
         fast_irq_output   <= |fast_act;
         normal_irq_output <= |norm_act;
      end
   end

   // -------------------------------------------------------------------------
   // Register writes
   // -------------------------------------------------------------------------
   // Class, enable and software request words
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fast_sel_ff <= RST_MASK;
         enable_ff   <= RST_MASK;
         soft_ff     <= RST_MASK;
         def_addr_ff <= RST_WORD;
      end
      else if (reg_write)
      begin
         case (reg_addr)
            REG_FAST_SELECT: fast_sel_ff <= reg_wdata[NUM_CHAN-1:0];
            REG_ENABLE:      enable_ff   <= enable_ff | reg_wdata[NUM_CHAN-1:0];
            REG_ENABLE_CLR:  enable_ff   <= enable_ff & ~reg_wdata[NUM_CHAN-1:0];
            REG_SOFT_SET:    soft_ff     <= soft_ff | reg_wdata[NUM_CHAN-1:0];
            REG_SOFT_CLR:    soft_ff     <= soft_ff & ~reg_wdata[NUM_CHAN-1:0];
            REG_DEF_ADDR:    def_addr_ff <= reg_wdata;
            default:         ;
         endcase
      end
   end

   // Per-slot address and control words
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         slot_en_ff <= '0;
         for (int s = 0; s < NUM_SLOTS; s++)
         begin
            slot_addr_ff[s] <= RST_WORD;
            slot_chan_ff[s] <= '0;
         end
      end
      else if (reg_write)
      begin
         for (int s = 0; s < NUM_SLOTS; s++)
         begin
            if (reg_addr == REG_SLOT_ADDR0 + ADDR_W'(4 * s))
            begin
               slot_addr_ff[s] <= reg_wdata;
            end
            if (reg_addr == REG_SLOT_CTRL0 + ADDR_W'(4 * s))
            begin
               slot_chan_ff[s] <= reg_wdata[CHAN_W-1:0];
               slot_en_ff[s]   <= reg_wdata[SLOT_EN_BIT];
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // Register reads
   // -------------------------------------------------------------------------
   // Read mux; unmapped addresses return zero
   always_comb
   begin
      nxt_rdata = '0;
      case (reg_addr)
         REG_IRQ_STATUS:  nxt_rdata = DATA_W'(norm_act);
         REG_FAST_STATUS: nxt_rdata = DATA_W'(fast_act);
         REG_RAW_STATUS:  nxt_rdata = DATA_W'(raw | soft_ff);
         REG_FAST_SELECT: nxt_rdata = DATA_W'(fast_sel_ff);
         REG_ENABLE:      nxt_rdata = DATA_W'(enable_ff);
         REG_SOFT_SET:    nxt_rdata = DATA_W'(soft_ff);
         REG_VECT_ADDR:   nxt_rdata = nxt_vect;
         REG_DEF_ADDR:    nxt_rdata = def_addr_ff;
         default:
         begin
            for (int s = 0; s < NUM_SLOTS; s++)
            begin
               if (reg_addr == REG_SLOT_ADDR0 + ADDR_W'(4 * s))
               begin
                  nxt_rdata = slot_addr_ff[s];
               end
               if (reg_addr == REG_SLOT_CTRL0 + ADDR_W'(4 * s))
               begin
                  nxt_rdata = DATA_W'({slot_en_ff[s], slot_chan_ff[s]});
               end
            end
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         reg_rdata <= RST_WORD;
      end
      else if (reg_read)
      begin
         reg_rdata <= nxt_rdata;
      end
      else
      begin
         reg_rdata <= RST_WORD;
      end
   end

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   property p_fast_merge;
      @(posedge clk) disable iff (!reset_n)
      (|((raw | soft_ff) & enable_ff & fast_sel_ff)) |=> fast_irq_output;
   endproperty
   a_fast_merge: assert property (p_fast_merge) else $error("fast output missed");

   property p_fast_clear;
      @(posedge clk) disable iff (!reset_n)
      (fast_act == '0) |=> !fast_irq_output;
   endproperty
   a_fast_clear: assert property (p_fast_clear) else $error("fast output stuck");

   property p_normal_out;
      @(posedge clk) disable iff (!reset_n)
      1'b1 |=> (normal_irq_output == (|$past(norm_act)));
   endproperty
   a_normal_out: assert property (p_normal_out) else $error("normal output wrong");

   property p_fast_excl;
      @(posedge clk) disable iff (!reset_n)
      (fast_act != '0 && norm_act == '0) |=> (fast_irq_output && !normal_irq_output);
   endproperty
   a_fast_excl: assert property (p_fast_excl) else $error("fast class leaked");

   property p_vect_slot0;
      @(posedge clk) disable iff (!reset_n)
      (reg_read && reg_addr == REG_VECT_ADDR && slot_hit[0]) |=> (reg_rdata == $past(slot_addr_ff[0]));
   endproperty
   a_vect_slot0: assert property (p_vect_slot0) else $error("slot 0 not first");

   property p_vect_def;
      @(posedge clk) disable iff (!reset_n)
      (reg_read && reg_addr == REG_VECT_ADDR && slot_hit == '0) |=> (reg_rdata == $past(def_addr_ff));
   endproperty
   a_vect_def: assert property (p_vect_def) else $error("default address wrong");

   property p_fast_status;
      @(posedge clk) disable iff (!reset_n)
      (reg_read && reg_addr == REG_FAST_STATUS) |=> (reg_rdata[NUM_CHAN-1:0] == $past(fast_act));
   endproperty
   a_fast_status: assert property (p_fast_status) else $error("fast status wrong");

   property p_irq_status;
      @(posedge clk) disable iff (!reset_n)
      (reg_read && reg_addr == REG_IRQ_STATUS) |=> (reg_rdata[NUM_CHAN-1:0] == $past(norm_act));
   endproperty
   a_irq_status: assert property (p_irq_status) else $error("normal status wrong");

   property p_uart1_msc;
      @(posedge clk) disable iff (!reset_n)
      (modem_status_change && enable_ff[CH_UART1] && !fast_sel_ff[CH_UART1]) |=> normal_irq_output;
   endproperty
   a_uart1_msc: assert property (p_uart1_msc) else $error("modem cause lost");

   // Software and single-line sources reach their class output one clock later
   property p_soft_only;
      @(posedge clk) disable iff (!reset_n)
      (soft_ff[CH_SOFT] && enable_ff[CH_SOFT] && !fast_sel_ff[CH_SOFT]) |=> normal_irq_output;
   endproperty
   a_soft_only: assert property (p_soft_only) else $error("software request lost");

   property p_wdog_fast;
      @(posedge clk) disable iff (!reset_n)
      (watchdog_request && enable_ff[CH_WATCHDOG] && fast_sel_ff[CH_WATCHDOG]) |=> fast_irq_output;
   endproperty
   a_wdog_fast: assert property (p_wdog_fast) else $error("watchdog fast request lost");

   property p_dbg_tx;
      @(posedge clk) disable iff (!reset_n)
      (debug_comm_transmit && enable_ff[CH_DBG_TX] && !fast_sel_ff[CH_DBG_TX]) |=> normal_irq_output;
   endproperty
   a_dbg_tx: assert property (p_dbg_tx) else $error("debug transmit request lost");

   property p_adc_map;
      @(posedge clk) disable iff (!reset_n)
      (adc_done && enable_ff[CH_ADC] && !fast_sel_ff[CH_ADC]) |=> normal_irq_output;
   endproperty
   a_adc_map: assert property (p_adc_map) else $error("converter request lost");

   // Merged multi-cause sources and external input 3 reach the normal output
   property p_timer_merge;
      @(posedge clk) disable iff (!reset_n)
      ((|timer1_match) && enable_ff[CH_TIMER1] && !fast_sel_ff[CH_TIMER1]) |=> normal_irq_output;
   endproperty
   a_timer_merge: assert property (p_timer_merge) else $error("timer match lost");

   property p_pwm_merge;
      @(posedge clk) disable iff (!reset_n)
      ((|pwm_match) && enable_ff[CH_PWM] && !fast_sel_ff[CH_PWM]) |=> normal_irq_output;
   endproperty
   a_pwm_merge: assert property (p_pwm_merge) else $error("modulator match lost");

   property p_rtc_merge;
      @(posedge clk) disable iff (!reset_n)
      ((rtc_increment_flag || rtc_alarm_flag) && enable_ff[CH_RTC] && !fast_sel_ff[CH_RTC]) |=> normal_irq_output;
   endproperty
   a_rtc_merge: assert property (p_rtc_merge) else $error("clock cause lost");

   property p_ext_map;
      @(posedge clk) disable iff (!reset_n)
      (external_irq[3] && enable_ff[CH_EXT0 + 3] && !fast_sel_ff[CH_EXT0 + 3]) |=> normal_irq_output;
   endproperty
   a_ext_map: assert property (p_ext_map) else $error("external input lost");

   property p_quiet;
      @(posedge clk) disable iff (!reset_n)
      (active == '0) |=> (!fast_irq_output && !normal_irq_output);
   endproperty
   a_quiet: assert property (p_quiet) else $error("output high with nothing active");

endmodule // vectored_irq_unit

// *** verilog/irq_ctrl_pkg.sv ***
//------------------------------------------------------------------------------
// Purpose : Constants for the vectored interrupt controller
// Assumes : 32-bit register port, byte addresses on the address, one word every 4
// Notes   : Channel map and register offsets live here only
//------------------------------------------------------------------------------
package irq_ctrl_pkg;

   // -------------------------------------------------------------------------
   // Sizes
   // -------------------------------------------------------------------------
   localparam int unsigned NUM_CHAN  = 19;
   localparam int unsigned NUM_SLOTS = 16;
   localparam int unsigned SLOT_W    = 4;
   localparam int unsigned CHAN_W    = 5;
   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned DATA_W    = 32;

   // -------------------------------------------------------------------------
   // Channel numbers
   // -------------------------------------------------------------------------
   localparam int unsigned CH_WATCHDOG = 0;
   localparam int unsigned CH_SOFT     = 1;
   localparam int unsigned CH_DBG_RX   = 2;
   localparam int unsigned CH_DBG_TX   = 3;
   localparam int unsigned CH_TIMER0   = 4;
   localparam int unsigned CH_TIMER1   = 5;
   localparam int unsigned CH_UART0    = 6;
   localparam int unsigned CH_UART1    = 7;
   localparam int unsigned CH_PWM      = 8;
   localparam int unsigned CH_TWI      = 9;
   localparam int unsigned CH_SPI0     = 10;
   localparam int unsigned CH_SPI1     = 11;
   localparam int unsigned CH_PLL      = 12;
   localparam int unsigned CH_RTC      = 13;
   localparam int unsigned CH_EXT0     = 14;
   localparam int unsigned CH_ADC      = 18;

   // -------------------------------------------------------------------------
   // Register byte addresses
   // -------------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] REG_IRQ_STATUS  = 8'h00;
   localparam logic [ADDR_W-1:0] REG_FAST_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] REG_RAW_STATUS  = 8'h08;
   localparam logic [ADDR_W-1:0] REG_FAST_SELECT = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_ENABLE      = 8'h10;
   localparam logic [ADDR_W-1:0] REG_ENABLE_CLR  = 8'h14;
   localparam logic [ADDR_W-1:0] REG_SOFT_SET    = 8'h18;
   localparam logic [ADDR_W-1:0] REG_SOFT_CLR    = 8'h1c;
   localparam logic [ADDR_W-1:0] REG_VECT_ADDR   = 8'h30;
   localparam logic [ADDR_W-1:0] REG_DEF_ADDR    = 8'h34;
   localparam logic [ADDR_W-1:0] REG_SLOT_ADDR0  = 8'h40;
   localparam logic [ADDR_W-1:0] REG_SLOT_CTRL0  = 8'h80;

   // -------------------------------------------------------------------------
   // Slot control fields and reset values
   // -------------------------------------------------------------------------
   localparam int unsigned SLOT_EN_BIT = 5;
   localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
   localparam logic [NUM_CHAN-1:0] RST_MASK = 19'h00000;

endpackage

// *** testbench/core_model.sv ***
//------------------------------------------------------------------------------
// Purpose : Processor core model taking fast and normal interrupt lines
// Assumes : Both lines are registered, active high, on clk
// Notes   : Counts each interrupt entry so the bench can see merged requests
//------------------------------------------------------------------------------
`timescale 1ns/100ps

module core_model
(
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic fast_irq_output,
   input  wire logic normal_irq_output,
   output int        fast_entries,
   output int        normal_entries
);
   logic fast_q_ff;
   logic normal_q_ff;

   // Take an interrupt on each rising level, as a core entering its handler
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         fast_q_ff      <= 1'b0;
         normal_q_ff    <= 1'b0;
         fast_entries   <= 0;
         normal_entries <= 0;
      end
      else
      begin
         fast_q_ff   <= fast_irq_output;
         normal_q_ff <= normal_irq_output;
         if (fast_irq_output && !fast_q_ff)
            fast_entries <= fast_entries + 1;
         if (normal_irq_output && !normal_q_ff)
            normal_entries <= normal_entries + 1;
      end
   end
endmodule // core_model

// *** testbench/tb_vectored_irq_unit.sv ***
//------------------------------------------------------------------------------
// Purpose : Self-checking bench for the vectored interrupt controller
// Assumes : Plain strobe register port, read data one cycle after strobe
// Notes   : Every channel source is driven; ports left idle stay low
//------------------------------------------------------------------------------
`timescale 1ns/100ps

module tb_vectored_irq_unit
   import irq_ctrl_pkg::*;
;
   logic clk = 0, reset_n = 0, reg_write = 0, reg_read = 0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, rd;
   logic watchdog_request = 0, debug_comm_receive = 0, debug_comm_transmit = 0, modem_status_change = 0;
   logic twi_state_change = 0, pll_locked = 0, rtc_increment_flag = 0, rtc_alarm_flag = 0, adc_done = 0;
   logic [3:0] timer0_match = '0, timer1_match = '0, uart0_causes = '0, uart1_causes = '0, external_irq = '0;
   logic [6:0] pwm_match = '0;
   logic [1:0] spi0_causes = '0, spi1_causes = '0;
   logic fast_irq_output, normal_irq_output;
   int   n_mismatch = 0, tests_run = 0, cycles = 0, fast_entries, normal_entries, f0;

   vectored_irq_unit u_vectored_irq_unit (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .watchdog_request(watchdog_request), .debug_comm_receive(debug_comm_receive),
      .debug_comm_transmit(debug_comm_transmit), .timer0_match(timer0_match), .timer1_match(timer1_match),
      .uart0_causes(uart0_causes), .uart1_causes(uart1_causes), .modem_status_change(modem_status_change),
      .pwm_match(pwm_match), .twi_state_change(twi_state_change), .spi0_causes(spi0_causes),
      .spi1_causes(spi1_causes), .pll_locked(pll_locked), .rtc_increment_flag(rtc_increment_flag),
      .rtc_alarm_flag(rtc_alarm_flag), .external_irq(external_irq), .adc_done(adc_done),
      .fast_irq_output(fast_irq_output), .normal_irq_output(normal_irq_output));

   core_model u_core_model (.clk(clk), .reset_n(reset_n), .fast_irq_output(fast_irq_output),
      .normal_irq_output(normal_irq_output), .fast_entries(fast_entries), .normal_entries(normal_entries));

   // ---------------------------------------------------------------------------
   // Clock, timeout and closing report
   // ---------------------------------------------------------------------------
   initial
   begin
      forever #5 clk = ~clk;
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Cut a hang short well past the expected few hundred cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_mismatch++;
         conclude();
      end
   end

   // ---------------------------------------------------------------------------
   // Register port and compare tasks
   // ---------------------------------------------------------------------------
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe edge
   task automatic rdw(input logic [ADDR_W-1:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      @(posedge clk);
      rd = reg_rdata;
   endtask

   task automatic cmp_w(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      rdw(a);
      tests_run++;
      if (rd !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t addr %h read %h want %h", $time, a, rd, exp);
      end
   endtask

   task automatic cmp_b(input logic got, input logic exp, input string what);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t %s is %b want %b", $time, what, got, exp);
      end
   endtask

   // Drive one source; 19 and 20 are the extra causes of channels 7 and 13
   task automatic set_src(input int c, input logic v);
      case (c)
         0: watchdog_request <= v;
         2: debug_comm_receive <= v;
         3: debug_comm_transmit <= v;
         4: timer0_match[0] <= v;
         5: timer1_match[1] <= v;
         6: uart0_causes[2] <= v;
         7: uart1_causes[3] <= v;
         8: pwm_match[6] <= v;
         9: twi_state_change <= v;
         10: spi0_causes[0] <= v;
         11: spi1_causes[1] <= v;
         12: pll_locked <= v;
         13: rtc_alarm_flag <= v;
         14: external_irq[0] <= v;
         15: external_irq[1] <= v;
         16: external_irq[2] <= v;
         17: external_irq[3] <= v;
         18: adc_done <= v;
         19: modem_status_change <= v;
         20: rtc_increment_flag <= v;
         default: ;
      endcase
      repeat (2) @(posedge clk);
   endtask

   // ---------------------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------------------
   task automatic t_reset();
      cmp_w(REG_ENABLE, RST_WORD);
      cmp_w(REG_FAST_SELECT, RST_WORD);
      cmp_w(REG_VECT_ADDR, RST_WORD);
      wr(8'hf0, 32'hffff_ffff);
      cmp_w(8'hf0, 32'h0000_0000);
      $display("test reset done");
   endtask

   // Each channel raises its own bit and the normal line, then drops
   task automatic t_channels();
      int ec;
      f0 = normal_entries;
      wr(REG_ENABLE, 32'h0007_ffff);
      for (int c = 0; c <= 20; c++)
      begin
         ec = (c == 19) ? 7 : (c == 20) ? 13 : c;
         if (c == 1)
            wr(REG_SOFT_SET, 32'h0000_0002);
         else
            set_src(c, 1'b1);
         cmp_w(REG_RAW_STATUS, 32'h1 << ec);
         cmp_w(REG_IRQ_STATUS, 32'h1 << ec);
         if (c == 1)
            cmp_w(REG_SOFT_SET, 32'h0000_0002);
         cmp_b(normal_irq_output, 1'b1, "normal");
         if (c == 1)
            wr(REG_SOFT_CLR, 32'h0000_0002);
         else
            set_src(c, 1'b0);
         rdw(REG_RAW_STATUS);
         cmp_b(normal_irq_output, 1'b0, "normal drop");
      end
      cmp_b(normal_entries == f0 + 21, 1'b1, "one normal entry per source");
      $display("test channels done");
   endtask

   // Two fast sources merge into one line beside a plain normal request
   task automatic t_fast();
      f0 = fast_entries;
      wr(REG_FAST_SELECT, 32'h0000_4001);
      watchdog_request <= 1'b1;
      external_irq[0]  <= 1'b1;
      set_src(9, 1'b1);
      cmp_w(REG_FAST_STATUS, 32'h0000_4001);
      cmp_w(REG_IRQ_STATUS, 32'h0000_0200);
      cmp_b(fast_irq_output, 1'b1, "fast");
      cmp_b(fast_entries == f0 + 1, 1'b1, "one fast entry");
      watchdog_request <= 1'b0;
      set_src(14, 1'b0);
      cmp_b(fast_irq_output, 1'b0, "fast drop");
      set_src(9, 1'b0);
      $display("test fast done");
   endtask

   // Slot 0 beats slot 15; fast-class channels never win a slot
   task automatic t_vector();
      wr(REG_FAST_SELECT, 32'h0000_0000);
      wr(REG_SLOT_CTRL0, 32'h0000_0026);
      wr(REG_SLOT_ADDR0, 32'h0000_1000);
      wr(REG_SLOT_CTRL0 + 8'h3c, 32'h0000_0028);
      wr(REG_SLOT_ADDR0 + 8'h3c, 32'h0000_2000);
      wr(REG_DEF_ADDR, 32'h0000_3000);
      cmp_w(REG_DEF_ADDR, 32'h0000_3000);
      cmp_w(REG_SLOT_CTRL0 + 8'h3c, 32'h0000_0028);
      set_src(8, 1'b1);
      set_src(9, 1'b1);
      cmp_w(REG_VECT_ADDR, 32'h0000_2000);
      set_src(6, 1'b1);
      cmp_w(REG_VECT_ADDR, 32'h0000_1000);
      set_src(6, 1'b0);
      wr(REG_FAST_SELECT, 32'h0000_0100);
      cmp_w(REG_VECT_ADDR, 32'h0000_3000);
      cmp_b(fast_irq_output, 1'b1, "fast over slot");
      cmp_b(normal_irq_output, 1'b1, "plain normal");
      wr(REG_ENABLE_CLR, 32'h0000_0200);
      rdw(REG_ENABLE);
      cmp_b(normal_irq_output, 1'b0, "masked normal");
      $display("test vector done");
   endtask

   // ---------------------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_channels();
      t_fast();
      t_vector();
      conclude();
   end
endmodule // tb_vectored_irq_unit
